// ---- pkg/ime_regs.svh ----
// Register offsets, field positions, reset values and response codes
// for the upper interrupt mask bytes. Assumes a 32-bit AXI4-Lite slave
// with one register per aligned word and 8-bit data in the low lane.
`ifndef IME_REGS_SVH
`define IME_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define IME_OFS_MASK_MID 8'h00
`define IME_OFS_MASK_HIGH 8'h04
`define IME_OFS_STAT_MID 8'h08
`define IME_OFS_STAT_HIGH 8'h0c
`define IME_OFS_PEND 8'h10

// ==========================================================
// Reset values and writable bits
`define IME_MASK_RST 8'h00
`define IME_STAT_RST 8'h00
`define IME_MID_WMASK 8'hff
`define IME_HIGH_WMASK 8'hdf
`define IME_DATA_ZERO 8'h00
`define IME_PAD_ZERO 24'h000000
`define IME_PEND_PAD 6'h00

// ==========================================================
// Middle byte field positions
`define IME_BIT_REF9 0
`define IME_BIT_REF10 1
`define IME_BIT_REF11 2
`define IME_BIT_REF12 3
`define IME_BIT_REF13 4
`define IME_BIT_REF14 5
`define IME_BIT_MAIN_FAIL 6
`define IME_BIT_OPMODE 7

// ==========================================================
// Upper byte field positions
`define IME_BIT_IN1_LOSS 0
`define IME_BIT_IN1_VIOL 1
`define IME_BIT_IN2_LOSS 2
`define IME_BIT_IN2_VIOL 3
`define IME_BIT_SEC_LOST 4
`define IME_BIT_UNUSED 5
`define IME_BIT_SEC_STATE 6
`define IME_BIT_EXT_ALARM 7

// ==========================================================
// Bus responses
`define IME_RESP_OKAY 2'b00
`define IME_RESP_SLVERR 2'b10

`endif

// ---- pkg/ime_pkg.sv ----
// Types shared by the interrupt mask block: state structs, phases and
// the register decode. Assumes ime_regs.svh is on the include path.
`include "ime_regs.svh"

package ime_pkg;

  // ==========================================================
  // Register select, one-hot
  typedef enum logic [5:0] {
    SEL_NONE = 6'b000001,
    SEL_MASK_MID = 6'b000010,
    SEL_MASK_HIGH = 6'b000100,
    SEL_STAT_MID = 6'b001000,
    SEL_STAT_HIGH = 6'b010000,
    SEL_PEND = 6'b100000
  } ime_sel_e;

  // ==========================================================
  // Bus channel phases, one-hot
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_RESP = 2'b10
  } ime_ph_e;

  typedef struct packed {
    logic [7:0] bits;
  } ime_byte_s;

  typedef struct packed {
    ime_ph_e wph;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic [1:0] bresp;
    ime_ph_e rph;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } ime_top_s;

  // ==========================================================
  // Decode, shared by the write and read paths
  function automatic ime_sel_e ime_decode(input logic [7:0] addr);
    ime_sel_e sel;
    sel = SEL_NONE;
    case ({addr[7:2], 2'b00})
      `IME_OFS_MASK_MID: sel = SEL_MASK_MID;
      `IME_OFS_MASK_HIGH: sel = SEL_MASK_HIGH;
      `IME_OFS_STAT_MID: sel = SEL_STAT_MID;
      `IME_OFS_STAT_HIGH: sel = SEL_STAT_HIGH;
      `IME_OFS_PEND: sel = SEL_PEND;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : ime_decode

endpackage : ime_pkg

// ---- hw/ime_mask_reg.sv ----
// One 8-bit software mask byte with a fixed set of writable bits.
// Assumes a one-cycle write strobe from the bus logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "ime_regs.svh"

module ime_mask_reg
  import ime_pkg::*;
#(
  parameter logic [7:0] WMASK = `IME_MID_WMASK
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [7:0] wdata,
  // Mask value
  output logic [7:0] q
);

  ime_byte_s st_reg;
  ime_byte_s st_next;

  // ==========================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    if (we)
    begin
      // Bits outside WMASK hold their reset zero forever
      st_next.bits = wdata & WMASK;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg.bits <= `IME_MASK_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.bits;

endmodule : ime_mask_reg

`default_nettype wire

// ---- hw/ime_status.sv ----
// Sticky event byte: each event flag sets its bit, a read clears the byte.
// Assumes event flags and the clear strobe come from the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "ime_regs.svh"

module ime_status
  import ime_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events and read clear
  input wire logic [7:0] evt,
  input wire logic clr,
  // Sticky flags
  output logic [7:0] q
);

  ime_byte_s st_reg;
  ime_byte_s st_next;

  // ==========================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    if (clr)
    begin
      st_next.bits = `IME_STAT_RST;
    end
    // Set after clear, so an event in the clearing cycle is kept
    st_next.bits = st_next.bits | evt;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg.bits <= `IME_STAT_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.bits;

endmodule : ime_status

`default_nettype wire

// ---- hw/ime_top.sv ----
// Upper interrupt mask bytes with sticky event flags and one level
// interrupt, reached over AXI4-Lite. Assumes event flags are produced
// by logic on MCLK, so they need no synchroniser.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ime_regs.svh"

module ime_top
  import ime_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // AXI4-Lite write address
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Event flags, middle byte sources
  input wire logic REF_INPUT_NINE,
  input wire logic REF_INPUT_TEN,
  input wire logic REF_INPUT_ELEVEN,
  input wire logic REF_INPUT_TWELVE,
  input wire logic REF_INPUT_THIRTEEN,
  input wire logic REF_INPUT_FOURTEEN,
  input wire logic MAIN_REF_FAILED,
  input wire logic OPERATING_MODE_CHANGE,
  // Event flags, upper byte sources
  input wire logic INPUT_ONE_SIGNAL_LOSS,
  input wire logic INPUT_ONE_CODE_VIOLATION,
  input wire logic INPUT_TWO_SIGNAL_LOSS,
  input wire logic INPUT_TWO_CODE_VIOLATION,
  input wire logic SECONDARY_PATH_INPUTS_LOST,
  input wire logic SECONDARY_PATH_STATE,
  input wire logic EXT_FRAME_INPUT_ALARM,
  // Interrupt
  output logic IRQ
);

  ime_top_s st_reg;
  ime_top_s st_next;

  logic [7:0] evt_mid;
  logic [7:0] evt_high;
  logic [7:0] mask_mid;
  logic [7:0] mask_high;
  logic [7:0] stat_mid;
  logic [7:0] stat_high;
  logic [7:0] pend_mid;
  logic [7:0] pend_high;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  ime_sel_e wr_sel;
  ime_sel_e rd_sel;
  logic we_mid;
  logic we_high;
  logic clr_mid;
  logic clr_high;

  // ==========================================================
  // Event vectors
  assign evt_mid[`IME_BIT_REF9] = REF_INPUT_NINE;
  assign evt_mid[`IME_BIT_REF10] = REF_INPUT_TEN;
  assign evt_mid[`IME_BIT_REF11] = REF_INPUT_ELEVEN;
  assign evt_mid[`IME_BIT_REF12] = REF_INPUT_TWELVE;
  assign evt_mid[`IME_BIT_REF13] = REF_INPUT_THIRTEEN;
  assign evt_mid[`IME_BIT_REF14] = REF_INPUT_FOURTEEN;
  assign evt_mid[`IME_BIT_MAIN_FAIL] = MAIN_REF_FAILED;
  assign evt_mid[`IME_BIT_OPMODE] = OPERATING_MODE_CHANGE;

  assign evt_high[`IME_BIT_IN1_LOSS] = INPUT_ONE_SIGNAL_LOSS;
  assign evt_high[`IME_BIT_IN1_VIOL] = INPUT_ONE_CODE_VIOLATION;
  assign evt_high[`IME_BIT_IN2_LOSS] = INPUT_TWO_SIGNAL_LOSS;
  assign evt_high[`IME_BIT_IN2_VIOL] = INPUT_TWO_CODE_VIOLATION;
  assign evt_high[`IME_BIT_SEC_LOST] = SECONDARY_PATH_INPUTS_LOST;
  assign evt_high[`IME_BIT_UNUSED] = 1'b0;
  assign evt_high[`IME_BIT_SEC_STATE] = SECONDARY_PATH_STATE;
  assign evt_high[`IME_BIT_EXT_ALARM] = EXT_FRAME_INPUT_ALARM;

  // ==========================================================
  // Bus handshakes and decode
  assign S_AXI_AWREADY = !st_reg.aw_held && (st_reg.wph == PH_IDLE);
  assign S_AXI_WREADY = !st_reg.w_held && (st_reg.wph == PH_IDLE);
  assign S_AXI_ARREADY = (st_reg.rph == PH_IDLE);
  assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;

  // Write commits one cycle after both halves are held; costs a cycle
  // but keeps the address and data paths free of the AXI inputs
  assign wr_go = st_reg.aw_held && st_reg.w_held && (st_reg.wph == PH_IDLE);
  assign wr_sel = ime_decode(st_reg.aw_addr);
  assign rd_sel = ime_decode(S_AXI_ARADDR);

  // Only lane 0 carries register data; other lanes are dropped
  assign we_mid = wr_go && st_reg.w_strb0 && (wr_sel == SEL_MASK_MID);
  assign we_high = wr_go && st_reg.w_strb0 && (wr_sel == SEL_MASK_HIGH);

  // Reading a status byte clears it
  assign clr_mid = ar_hs && (rd_sel == SEL_STAT_MID);
  assign clr_high = ar_hs && (rd_sel == SEL_STAT_HIGH);

  // ==========================================================
  // Mask and status bytes
  ime_mask_reg #(
    .WMASK(`IME_MID_WMASK)
  ) u_mask_mid (
    .clk(MCLK),
    .rst_n(RESET_N),
    .we(we_mid),
    .wdata(st_reg.w_data),
    .q(mask_mid)
  );

  ime_mask_reg #(
    .WMASK(`IME_HIGH_WMASK)
  ) u_mask_high (
    .clk(MCLK),
    .rst_n(RESET_N),
    .we(we_high),
    .wdata(st_reg.w_data),
    .q(mask_high)
  );

  // Masked events are recorded all the same
  ime_status u_stat_mid (
    .clk(MCLK),
    .rst_n(RESET_N),
    .evt(evt_mid),
    .clr(clr_mid),
    .q(stat_mid)
  );

  ime_status u_stat_high (
    .clk(MCLK),
    .rst_n(RESET_N),
    .evt(evt_high),
    .clr(clr_high),
    .q(stat_high)
  );

  // ==========================================================
  // Mask gating
  assign pend_mid[`IME_BIT_REF9] = stat_mid[`IME_BIT_REF9] & mask_mid[`IME_BIT_REF9];
  assign pend_mid[`IME_BIT_REF10] = stat_mid[`IME_BIT_REF10] & mask_mid[`IME_BIT_REF10];
  assign pend_mid[`IME_BIT_REF11] = stat_mid[`IME_BIT_REF11] & mask_mid[`IME_BIT_REF11];
  assign pend_mid[`IME_BIT_REF12] = stat_mid[`IME_BIT_REF12] & mask_mid[`IME_BIT_REF12];
  assign pend_mid[`IME_BIT_REF13] = stat_mid[`IME_BIT_REF13] & mask_mid[`IME_BIT_REF13];
  assign pend_mid[`IME_BIT_REF14] = stat_mid[`IME_BIT_REF14] & mask_mid[`IME_BIT_REF14];
  assign pend_mid[`IME_BIT_MAIN_FAIL] =
    stat_mid[`IME_BIT_MAIN_FAIL] & mask_mid[`IME_BIT_MAIN_FAIL];
  assign pend_mid[`IME_BIT_OPMODE] = stat_mid[`IME_BIT_OPMODE] & mask_mid[`IME_BIT_OPMODE];

  assign pend_high[`IME_BIT_IN1_LOSS] = stat_high[`IME_BIT_IN1_LOSS] & mask_high[`IME_BIT_IN1_LOSS];
  assign pend_high[`IME_BIT_IN1_VIOL] = stat_high[`IME_BIT_IN1_VIOL] & mask_high[`IME_BIT_IN1_VIOL];
  assign pend_high[`IME_BIT_IN2_LOSS] =
    stat_high[`IME_BIT_IN2_LOSS] & mask_high[`IME_BIT_IN2_LOSS];
  assign pend_high[`IME_BIT_IN2_VIOL] =
    stat_high[`IME_BIT_IN2_VIOL] & mask_high[`IME_BIT_IN2_VIOL];
  assign pend_high[`IME_BIT_SEC_LOST] =
    stat_high[`IME_BIT_SEC_LOST] & mask_high[`IME_BIT_SEC_LOST];
  assign pend_high[`IME_BIT_UNUSED] = 1'b0;
  assign pend_high[`IME_BIT_SEC_STATE] =
    stat_high[`IME_BIT_SEC_STATE] & mask_high[`IME_BIT_SEC_STATE];
  assign pend_high[`IME_BIT_EXT_ALARM] =
    stat_high[`IME_BIT_EXT_ALARM] & mask_high[`IME_BIT_EXT_ALARM];

  // ==========================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.irq = (|pend_mid) | (|pend_high);

    // Write address and data, taken in either order
    if (aw_hs)
    begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = S_AXI_AWADDR;
    end
    if (w_hs)
    begin
      st_next.w_held = 1'b1;
      st_next.w_data = S_AXI_WDATA[7:0];
      st_next.w_strb0 = S_AXI_WSTRB[0];
    end

    case (st_reg.wph)
      PH_IDLE:
      begin
        if (wr_go)
        begin
          st_next.aw_held = 1'b0;
          st_next.w_held = 1'b0;
          st_next.wph = PH_RESP;
          if (wr_sel == SEL_MASK_MID || wr_sel == SEL_MASK_HIGH)
          begin
            st_next.bresp = `IME_RESP_OKAY;
          end
          else
          begin
            // Status and pending bytes are read only
            st_next.bresp = `IME_RESP_SLVERR;
          end
        end
      end
      PH_RESP:
      begin
        if (S_AXI_BREADY)
        begin
          st_next.wph = PH_IDLE;
        end
      end
      default:
      begin
        st_next.wph = PH_IDLE;
      end
    endcase

    case (st_reg.rph)
      PH_IDLE:
      begin
        if (ar_hs)
        begin
          st_next.rph = PH_RESP;
          st_next.rresp = `IME_RESP_OKAY;
          case (rd_sel)
            SEL_MASK_MID: st_next.rdata = mask_mid;
            SEL_MASK_HIGH: st_next.rdata = mask_high;
            SEL_STAT_MID: st_next.rdata = stat_mid;
            SEL_STAT_HIGH: st_next.rdata = stat_high;
            SEL_PEND: st_next.rdata = {`IME_PEND_PAD, |pend_high, |pend_mid};
            default:
            begin
              st_next.rdata = `IME_DATA_ZERO;
              st_next.rresp = `IME_RESP_SLVERR;
            end
          endcase
        end
      end
      PH_RESP:
      begin
        if (S_AXI_RREADY)
        begin
          st_next.rph = PH_IDLE;
        end
      end
      default:
      begin
        st_next.rph = PH_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      st_reg.wph <= PH_IDLE;
      st_reg.aw_held <= 1'b0;
      st_reg.aw_addr <= `IME_OFS_MASK_MID;
      st_reg.w_held <= 1'b0;
      st_reg.w_data <= `IME_DATA_ZERO;
      st_reg.w_strb0 <= 1'b0;
      st_reg.bresp <= `IME_RESP_OKAY;
      st_reg.rph <= PH_IDLE;
      st_reg.rdata <= `IME_DATA_ZERO;
      st_reg.rresp <= `IME_RESP_OKAY;
      st_reg.irq <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign S_AXI_BVALID = (st_reg.wph == PH_RESP);
  assign S_AXI_BRESP = st_reg.bresp;
  assign S_AXI_RVALID = (st_reg.rph == PH_RESP);
  assign S_AXI_RRESP = st_reg.rresp;
  assign S_AXI_RDATA = {`IME_PAD_ZERO, st_reg.rdata};
  assign IRQ = st_reg.irq;

endmodule : ime_top

`default_nettype wire

// ---- verif/ime_host_model.sv ----
// Host model: a register-bus master with blocking write and read tasks.
// Assumes the bench calls at most one write and one read at a time.
`timescale 1ns/1ns
`default_nettype none

module ime_host_model
(
  // Clock
  input wire logic mclk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ==========
  // Stall control: cycles before a response is accepted
  int unsigned lazy = 0;

  initial
  begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // ==========
  // Transfers; released payloads are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    logic b;
    int unsigned n;
    n = 0;
    b = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lazy == 0);
    while (!b)
    begin
      @(negedge mclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      r = bresp;
      @(posedge mclk);
      n++;
      if (aw)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (!b && n >= lazy) bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    logic rv;
    int unsigned n;
    n = 0;
    rv = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lazy == 0);
    while (!rv)
    begin
      @(negedge mclk);
      ar = arvalid && arready;
      rv = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      n++;
      if (ar)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (!rv && n >= lazy) rready <= 1'b1;
    end
    rready <= 1'b0;
  endtask : rd
endmodule : ime_host_model

`default_nettype wire

// ---- verif/ime_top_assertions.sv ----
// Checker for the interrupt mask block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module ime_top_assertions
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Register bus
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Interrupt
  input wire logic IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // ==========
  // Properties
  property p_irq_rst;
    $rose(RESET_N) |-> !IRQ [*3];
  endproperty
  // Both halves are held for a cycle before the commit, so the answer is two edges on
  property p_wr_ans;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  property p_b_refuse;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  property p_rd_ans;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
  endproperty
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  property p_r_pad;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] == 6'h01 |=>
      S_AXI_RDATA[31:8] == 24'h000000 && !S_AXI_RDATA[5];
  endproperty
  // IRQ may only drop after a read clear or a mask write
  property p_irq_fall;
    $fell(IRQ) |-> $past(S_AXI_RVALID) || $past(S_AXI_BVALID);
  endproperty

  // ==========
  // Assertions and covers
  a_irq_rst: assert property (p_irq_rst) else $error("IRQ raised right after reset");
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_b_refuse: assert property (p_b_refuse) else $error("write taken while response pending");
  a_rd_ans: assert property (p_rd_ans) else $error("read data late");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_r_pad: assert property (p_r_pad) else $error("unused upper mask bit read set");
  a_irq_fall: assert property (p_irq_fall) else $error("IRQ dropped without cause");
  c_irq: cover property ($rose(IRQ));
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'b10);
  c_stall: cover property (S_AXI_RVALID && !S_AXI_RREADY);
endmodule : ime_top_assertions

bind ime_top ime_top_assertions i_ime_top_assertions (
  .MCLK(MCLK), .RESET_N(RESET_N), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ));

`default_nettype wire

// ---- verif/tb_ime_top.sv ----
// Bench for the interrupt mask block: register bus through the host model,
// event flags driven here. Assumes one 125 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "ime_regs.svh"
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end

module tb_ime_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] ev_mid = 8'h00;
  logic [7:0] ev_high = 8'h00;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
  int failures = 0;
  int num_checks = 0;
  int hi_bits [5] = '{7, 6, 4, 3, 2};

  always #4 mclk = ~mclk;

  ime_host_model i_ime_host_model (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  ime_top i_ime_top (.MCLK(mclk), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .REF_INPUT_NINE(ev_mid[0]), .REF_INPUT_TEN(ev_mid[1]),
    .REF_INPUT_ELEVEN(ev_mid[2]), .REF_INPUT_TWELVE(ev_mid[3]), .REF_INPUT_THIRTEEN(ev_mid[4]),
    .REF_INPUT_FOURTEEN(ev_mid[5]), .MAIN_REF_FAILED(ev_mid[6]), .OPERATING_MODE_CHANGE(ev_mid[7]),
    .INPUT_ONE_SIGNAL_LOSS(ev_high[0]), .INPUT_ONE_CODE_VIOLATION(ev_high[1]),
    .INPUT_TWO_SIGNAL_LOSS(ev_high[2]), .INPUT_TWO_CODE_VIOLATION(ev_high[3]),
    .SECONDARY_PATH_INPUTS_LOST(ev_high[4]), .SECONDARY_PATH_STATE(ev_high[6]),
    .EXT_FRAME_INPUT_ALARM(ev_high[7]), .IRQ(irq));

  // ==========
  // Bus and event helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ime_host_model.wr(a, {24'h000000, d}, rsp);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    i_ime_host_model.rd(a, rdat, rsp);
  endtask : rd

  // One-cycle event, then time for status and IRQ to settle
  task automatic pulse(input logic hi, input logic [7:0] one);
    @(posedge mclk);
    if (hi) ev_high <= one;
    else ev_mid <= one;
    @(posedge mclk);
    ev_high <= 8'h00;
    ev_mid <= 8'h00;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : pulse

  // ==========
  // Scenarios
  task automatic t_reset_values;
    rd(`IME_OFS_MASK_MID);
    `CHK("mask mid", 32'h00000000, rdat)
    rd(`IME_OFS_MASK_HIGH);
    `CHK("mask high", 32'h00000000, rdat)
  endtask : t_reset_values

  // Slow responses from the host here, to exercise held answers
  task automatic t_mask_rw;
    i_ime_host_model.lazy = 3;
    wr(`IME_OFS_MASK_MID, 8'hff);
    `CHK("bresp", 2'b00, rsp)
    rd(`IME_OFS_MASK_MID);
    `CHK("mask mid", 32'h000000ff, rdat)
    wr(`IME_OFS_MASK_HIGH, 8'hff);
    rd(`IME_OFS_MASK_HIGH);
    `CHK("mask high", 32'h000000df, rdat)
    i_ime_host_model.lazy = 0;
    wr(`IME_OFS_MASK_MID, 8'h00);
    wr(`IME_OFS_MASK_HIGH, 8'h00);
  endtask : t_mask_rw

  task automatic t_unmapped;
    wr(`IME_OFS_STAT_MID, 8'hff);
    `CHK("status write resp", 2'b10, rsp)
    rd(8'h20);
    `CHK("unmapped data", 32'h00000000, rdat)
    `CHK("unmapped resp", 2'b10, rsp)
  endtask : t_unmapped

  // Every other bit enabled must not let this source through
  task automatic t_gate(input logic hi, input int b);
    logic [7:0] one;
    logic [7:0] ofs_m;
    logic [7:0] ofs_s;
    one = 8'h01 << b;
    ofs_m = hi ? `IME_OFS_MASK_HIGH : `IME_OFS_MASK_MID;
    ofs_s = hi ? `IME_OFS_STAT_HIGH : `IME_OFS_STAT_MID;
    wr(ofs_m, ~one);
    pulse(hi, one);
    `CHK("irq blocked", 1'b0, irq)
    rd(ofs_s);
    `CHK("status", {24'h000000, one}, rdat)
    wr(ofs_m, one);
    pulse(hi, one);
    `CHK("irq allowed", 1'b1, irq)
    rd(`IME_OFS_PEND);
    `CHK("pending", hi ? 32'h00000002 : 32'h00000001, rdat)
    rd(ofs_s);
    `CHK("status allowed", {24'h000000, one}, rdat)
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("irq cleared", 1'b0, irq)
    wr(ofs_m, 8'h00);
  endtask : t_gate

  // ==========
  // Verdict
  task automatic summarize;
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset_values();
    t_mask_rw();
    t_unmapped();
    for (int b = 0; b < 7; b++)
      t_gate(1'b0, b);
    foreach (hi_bits[k])
      t_gate(1'b1, hi_bits[k]);
    summarize();
  end

  // Twelve gate runs of under a hundred cycles each; ample margin
  initial
  begin
    #400000;
    failures++;
    summarize();
  end
endmodule : tb_ime_top

`default_nettype wire
